// >>> fifo18_map.svh
// constants and bit positions for the 18-bit cascadable fifo and its user end
// assumes inclusion by bare name from the package alone; the design modules do not include it
`ifndef FIFO18_MAP_SVH
`define FIFO18_MAP_SVH
`define DATA_W 18
`define DEPTH 64
`define PTR_W 6
`define CNT_W 7
`define HALF_LEVEL 7'h20
`define NEAR_EMPTY_RST 18'h00007
`define NEAR_FULL_RST 18'h00007
`define BUF_DEPTH 2
`endif

// >>> fifo18_pkg.sv
// types shared by the fifo device and its user end
// assumes the map header sits in the same folder
package fifo18_pkg;
  `include "fifo18_map.svh"
  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`PTR_W-1:0] ptr_t;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef enum logic {OFS_EMPTY_SEL, OFS_FULL_SEL} ofs_sel_e;
endpackage

// >>> fifo18_if.sv
// pin-level link between the fifo device and the user end
// assumes one shared clock; rd_data is always driven and rd_data_oe only reports the output enable
interface fifo18_if (
  input logic clk
);
  import fifo18_pkg::*;
  word_t wr_data;
  logic wr_en_n;
  logic rd_en_n;
  logic offset_load_n;
  logic out_en_n;
  logic flag_sync_select;
  logic first_in_chain_n;
  logic wr_chain_in_n;
  logic rd_chain_in_n;
  logic replay_n;
  word_t rd_data;
  logic rd_data_oe;
  logic empty_flag_n;
  logic full_flag_n;
  logic near_empty_flag_n;
  logic near_full_flag_n;
  logic half_level_flag_n;
  logic wr_chain_out_n;
  logic rd_chain_out_n;
  modport dev (
    input wr_data, wr_en_n, rd_en_n, offset_load_n, out_en_n, flag_sync_select,
    input first_in_chain_n, wr_chain_in_n, rd_chain_in_n, replay_n,
    output rd_data, rd_data_oe, empty_flag_n, full_flag_n, near_empty_flag_n,
    output near_full_flag_n, half_level_flag_n, wr_chain_out_n, rd_chain_out_n
  );
  modport user (
    output wr_data, wr_en_n, rd_en_n, offset_load_n, out_en_n, flag_sync_select,
    output first_in_chain_n, wr_chain_in_n, rd_chain_in_n, replay_n,
    input rd_data, rd_data_oe, empty_flag_n, full_flag_n, near_empty_flag_n,
    input near_full_flag_n, half_level_flag_n, wr_chain_out_n, rd_chain_out_n
  );
endinterface

// >>> fifo18_dev.sv
// the fifo device: storage, pointers, flags, offset register, chain outputs
// assumes one clock for both ports and inputs synchronous to it
module fifo18_dev
  import fifo18_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fifo18_if.dev pins
);
  // storage of DEPTH words of 18 bits in flip-flops
  word_t mem_q [`DEPTH];
  ptr_t wr_ptr_q, rd_ptr_q;
  cnt_t level_q;
  word_t rd_data_q, ofs_empty_q, ofs_full_q;
  ofs_sel_e ofs_rd_sel_q, ofs_wr_sel_q;
  logic empty_n_q, full_n_q, near_e_q, near_f_q, oe_q;
  logic near_e_comb, near_f_comb, do_wr, do_rd, ld;
  // cascade bookkeeping: ring strap, port ownership and the pass pulses
  logic cascade_q, wr_tok_q, rd_tok_q, wr_last, rd_last;
  logic wr_chain_n_q, rd_chain_n_q;
  cnt_t level_d;

  // offset access borrows both enables, so it blocks the data path
  assign ld = !pins.offset_load_n;
  // writes gated by full, reads by empty
  // in a ring a port only moves while this device owns it
  assign do_wr = !pins.wr_en_n && !ld && full_n_q && (wr_tok_q || !cascade_q);
  assign do_rd = !pins.rd_en_n && !ld && empty_n_q && (rd_tok_q || !cascade_q);
  // one level counter sees both ports at the same edge, so a
  // simultaneous read and write can never race on the fill count
  assign level_d = level_q + cnt_t'(do_wr) - cnt_t'(do_rd);
  // the last location of each port hands that port to the next device
  assign wr_last = do_wr && cascade_q && (wr_ptr_q == ptr_t'(`DEPTH - 1));
  assign rd_last = do_rd && cascade_q && (rd_ptr_q == ptr_t'(`DEPTH - 1));
  // live comparison used in the unregistered near-flag mode
  assign near_e_comb = ({11'h000, level_q} <= ofs_empty_q);
  assign near_f_comb = ({11'h000, level_q} >= (18'(`DEPTH) - ofs_full_q));

  // store every enabled cycle, no idle needed; one row of flops per
  // entry, loaded only when the write pointer selects it
  for (genvar e = 0; e < `DEPTH; e++) begin : g_row
    always_ff @(posedge clk) begin
      if (do_wr && (wr_ptr_q == ptr_t'(e))) begin
        mem_q[e] <= pins.wr_data;
      end
    end
  end

  // write pointer zero after reset; it wraps through every row
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
    end else if (do_wr) begin
      wr_ptr_q <= wr_ptr_q + ptr_t'(1);
    end
  end

  // read pointer zero after reset, moved only by accepted reads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr_q <= '0;
    end else if (do_rd) begin
      rd_ptr_q <= rd_ptr_q + ptr_t'(1);
    end
  end

  // level follows both ports; unchanged on a simultaneous pair
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

  // next word presented on the read edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else if (do_rd) begin
      rd_data_q <= mem_q[rd_ptr_q];
    end else if (ld && !pins.rd_en_n) begin
      // offset register read out, empty offset first
      rd_data_q <= (ofs_rd_sel_q == OFS_EMPTY_SEL) ? ofs_empty_q : ofs_full_q;
    end
  end

  // offset load alternates empty then full offset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ofs_empty_q <= `NEAR_EMPTY_RST;
      ofs_full_q <= `NEAR_FULL_RST;
    end else if (ld && !pins.wr_en_n) begin
      if (ofs_wr_sel_q == OFS_EMPTY_SEL) ofs_empty_q <= pins.wr_data;
      else ofs_full_q <= pins.wr_data;
    end
  end

  // load and readback each walk the offset pair on their own, so a
  // readback between two loads does not disturb the load order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ofs_wr_sel_q <= OFS_EMPTY_SEL;
      ofs_rd_sel_q <= OFS_EMPTY_SEL;
    end else begin
      if (ld && !pins.wr_en_n) begin
        ofs_wr_sel_q <= (ofs_wr_sel_q == OFS_EMPTY_SEL) ? OFS_FULL_SEL : OFS_EMPTY_SEL;
      end
      if (ld && !pins.rd_en_n) begin
        ofs_rd_sel_q <= (ofs_rd_sel_q == OFS_EMPTY_SEL) ? OFS_FULL_SEL : OFS_EMPTY_SEL;
      end
    end
  end

  // empty/full registered, active low, empty after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      empty_n_q <= 1'b0;
      full_n_q <= 1'b1;
    end else begin
      empty_n_q <= !((level_q == 7'h00 && !do_wr) || (level_q == 7'h01 && do_rd && !do_wr));
      full_n_q <= !((level_q == cnt_t'(`DEPTH) && !do_rd) ||
                    (level_q == cnt_t'(`DEPTH - 1) && do_wr && !do_rd));
    end
  end

  // registered copies of the near flags (high = near)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      near_e_q <= 1'b1;
      near_f_q <= 1'b0;
    end else begin
      near_e_q <= near_e_comb;
      near_f_q <= near_f_comb;
    end
  end

  // output enable sampled, read state untouched
  always_ff @(posedge clk) begin
    if (!rst_n) oe_q <= 1'b0;
    else oe_q <= !pins.out_en_n;
  end

  // ring strap sampled while reset is held: a chain input idling high
  // means a previous device drives it, standalone straps tie it low.
  // in a ring hold reset two edges so the neighbour's output has settled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cascade_q <= pins.wr_chain_in_n;
    end
  end

  // write ownership: the first device starts with it, a pulse on
  // the write chain input brings it back after the ring has gone round
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_tok_q <= !pins.first_in_chain_n;
    end else if (wr_last) begin
      wr_tok_q <= 1'b0;
    end else if (cascade_q && !pins.wr_chain_in_n) begin
      wr_tok_q <= 1'b1;
    end
  end

  // read ownership follows the same ring one block behind, so
  // words leave the devices in the order in which they were stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_tok_q <= !pins.first_in_chain_n;
    end else if (rd_last) begin
      rd_tok_q <= 1'b0;
    end else if (cascade_q && !pins.rd_chain_in_n) begin
      rd_tok_q <= 1'b1;
    end
  end

  // shared pin: half flag when standalone, one-cycle pass pulse
  // in a ring; registered from the next level or wr_last so the pin never glitches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_chain_n_q <= 1'b1;
    end else if (cascade_q) begin
      wr_chain_n_q <= !wr_last;
    end else begin
      wr_chain_n_q <= !(level_d >= `HALF_LEVEL);
    end
  end

  // read chain pulses once as the last row is read in a ring; idle high otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_chain_n_q <= 1'b1;
    end else begin
      rd_chain_n_q <= !rd_last;
    end
  end

  // five status outputs, all but the live near flags straight from flops
  assign pins.rd_data = rd_data_q;
  assign pins.rd_data_oe = oe_q;
  assign pins.empty_flag_n = empty_n_q;
  assign pins.full_flag_n = full_n_q;
  // select low picks the registered flag, high follows the level
  assign pins.near_empty_flag_n = !(pins.flag_sync_select ? near_e_comb : near_e_q);
  assign pins.near_full_flag_n = !(pins.flag_sync_select ? near_f_comb : near_f_q);
  // half flag and write chain output are one pin
  assign pins.half_level_flag_n = wr_chain_n_q;
  assign pins.wr_chain_out_n = wr_chain_n_q;
  assign pins.rd_chain_out_n = rd_chain_n_q;
endmodule

// >>> fifo18_user.sv
// user end: producer through a two-entry buffer, consumer with ready
// assumes one clock; standalone chain straps (first device, chain inputs low)
module fifo18_user
  import fifo18_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fifo18_if.user pins,
  input wire logic src_valid,
  input wire word_t src_data,
  output logic src_ready,
  output logic snk_valid,
  output word_t snk_data,
  input wire logic snk_ready
);
  word_t buf_q [`BUF_DEPTH];
  logic [1:0] cnt_q;
  logic head_q, tail_q, wen_q, ren_q, rd_pend_q;
  word_t wdata_q;
  logic push, pop;

  assign push = src_valid && src_ready;
  // feed the device only while it is not full; back to back while
  // the registered near-full flag is clear, every other cycle near the top,
  // because the full flag lags a write by one edge
  assign pop = (cnt_q != 2'h0) && pins.full_flag_n && (!wen_q || pins.near_full_flag_n);

  // two-entry buffer ahead of the device, stalls the source when full
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      head_q <= 1'b0;
      tail_q <= 1'b0;
      src_ready <= 1'b0;
    end else begin
      if (push) buf_q[tail_q] <= src_data;
      if (push) tail_q <= !tail_q;
      if (pop) head_q <= !head_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
      src_ready <= (cnt_q + 2'(push) - 2'(pop)) < 2'(`BUF_DEPTH);
    end
  end

  // drive one write per popped word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wen_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      wen_q <= pop;
      if (pop) wdata_q <= buf_q[head_q];
    end
  end

  // read when not empty and the sink has room
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ren_q <= 1'b0;
      rd_pend_q <= 1'b0;
      snk_valid <= 1'b0;
      snk_data <= '0;
    end else begin
      ren_q <= pins.empty_flag_n && !ren_q && !rd_pend_q && !snk_valid;
      rd_pend_q <= ren_q;
      if (rd_pend_q) begin
        snk_valid <= 1'b1;
        snk_data <= pins.rd_data;
      end else if (snk_ready) begin
        snk_valid <= 1'b0;
      end
    end
  end

  assign pins.wr_data = wdata_q;
  assign pins.wr_en_n = !wen_q;
  assign pins.rd_en_n = !ren_q;
  // offsets left at their reset values
  assign pins.offset_load_n = 1'b1;
  assign pins.out_en_n = 1'b0;
  assign pins.flag_sync_select = 1'b0;
  // standalone: first device, chain inputs tied low
  assign pins.first_in_chain_n = 1'b0;
  assign pins.wr_chain_in_n = 1'b0;
  assign pins.rd_chain_in_n = 1'b0;
  assign pins.replay_n = 1'b1;
endmodule

// >>> fifo18_props.sv
// checker on the fifo link signals
// assumes one clock; signals taken as plain inputs
module fifo18_props
  import fifo18_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic offset_load_n,
  input wire word_t rd_data,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic half_level_flag_n,
  input wire logic wr_chain_out_n,
  input wire logic rd_chain_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // both ports share one clock, so one default domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_empty: assert property ($rose(rst_n) |-> !empty_flag_n && full_flag_n)
    else $error("not empty after reset");
  a_write_fills: assert property (!wr_en_n && offset_load_n && full_flag_n |=> empty_flag_n)
    else $error("write lost");
  a_empty_idle: assert property (!empty_flag_n && wr_en_n && offset_load_n |=>
    !empty_flag_n && $stable(rd_data)) else $error("read while empty");
  a_full_holds: assert property (!full_flag_n && rd_en_n |=> !full_flag_n)
    else $error("full dropped without read");
  a_full_by_write: assert property ($fell(full_flag_n) |-> $past(!wr_en_n))
    else $error("full without write");
  a_flags_exclusive: assert property (full_flag_n || empty_flag_n)
    else $error("full and empty together");
  a_half_shared: assert property (half_level_flag_n == wr_chain_out_n)
    else $error("half flag not shared");
  a_chain_ring: assert property (!rd_chain_out_n |-> $past(!rd_en_n))
    else $error("read chain pulse without read");
endmodule

// >>> fifo18_bench.sv
// bench: device and user end joined by the link
// assumes package, interface, both ends and checker compile first
module fifo18_bench
  import fifo18_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst_n = 0;
  logic src_valid = 0;
  word_t src_data = '0;
  logic src_ready;
  logic snk_valid;
  word_t snk_data;
  logic snk_ready = 0;
  int err_count = 0;
  int n_tests = 0;
  int n_in;
  fifo18_if pins (.clk(clk));
  fifo18_dev i_fifo18_dev (.clk(clk), .rst_n(rst_n), .pins(pins));
  fifo18_user i_fifo18_user (.clk(clk), .rst_n(rst_n), .pins(pins), .src_valid(src_valid),
    .src_data(src_data), .src_ready(src_ready), .snk_valid(snk_valid), .snk_data(snk_data),
    .snk_ready(snk_ready));
  fifo18_props i_fifo18_props (.clk(clk), .rst_n(rst_n), .wr_en_n(pins.wr_en_n),
    .rd_en_n(pins.rd_en_n), .offset_load_n(pins.offset_load_n), .rd_data(pins.rd_data),
    .empty_flag_n(pins.empty_flag_n), .full_flag_n(pins.full_flag_n),
    .half_level_flag_n(pins.half_level_flag_n), .wr_chain_out_n(pins.wr_chain_out_n),
    .rd_chain_out_n(pins.rd_chain_out_n));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic check(string what, word_t seen, word_t exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // producer: holds valid, new word each cycle a word is taken
  task automatic send(int n, word_t base);
    n_in = 0;
    src_valid = 1;
    for (int c = 0; c < 120 && n_in < n; c++) begin
      src_data = word_t'(n_in) ^ base;
      if (src_ready === 1'b1) n_in++;
      @(negedge clk);
    end
    src_valid = 0;
  endtask
  // consumer: optional one-cycle stall before each take
  task automatic drain(int n, word_t base, bit stall);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (snk_valid !== 1'b1 && t < 40) begin
        @(negedge clk);
        t++;
      end
      if (stall) @(negedge clk);
      check("word", snk_data, word_t'(k) ^ base);
      snk_ready = 1;
      @(negedge clk);
      snk_ready = 0;
    end
  endtask
  task automatic t_reset();
    repeat (8) @(negedge clk);
    check("empty at reset", pins.empty_flag_n, 18'h0);
    check("full at reset", pins.full_flag_n, 18'h1);
    rst_n = 1;
    $display("test reset done");
  endtask
  // stalled sink lets the device fill; refused writes must not lose words
  task automatic t_fill();
    send(100, 18'h2AAAA);
    check("full flag", pins.full_flag_n, 18'h0);
    check("output drive", pins.rd_data_oe, 18'h1);
    check("near full", pins.near_full_flag_n, 18'h0);
    check("near empty off", pins.near_empty_flag_n, 18'h1);
    check("read chain idle", pins.rd_chain_out_n, 18'h1);
    check("half flag", pins.half_level_flag_n, 18'h0);
    check("depth", 18'(n_in > 64), 18'h1);
    drain(n_in, 18'h2AAAA, 1'b0);
    repeat (4) @(negedge clk);
    check("empty flag", pins.empty_flag_n, 18'h0);
    check("half clear", pins.half_level_flag_n, 18'h1);
    check("near empty", pins.near_empty_flag_n, 18'h0);
    check("near full off", pins.near_full_flag_n, 18'h1);
    $display("test fill done");
  endtask
  // back-to-back writes alongside stalled reads
  task automatic t_stream();
    fork
      send(40, 18'h15555);
      drain(40, 18'h15555, 1'b1);
    join
    check("count", 18'(n_in), 18'h28);
    $display("test stream done");
  endtask
  initial begin
    t_reset();
    t_fill();
    t_stream();
    conclude();
  end
  // watchdog cuts a hang short well beyond the expected run
  initial begin
    #60us;
    err_count++;
    conclude();
  end
endmodule
